//--- pkg/lcn_pkg.sv
// package for the link control and node identity register block
// What this block does, and what software must do
// R01 - set and clear addresses read same register
// R02 - set port: ones set bits
// R03 - clear port: ones clear bits
// R04 - external source advances tally, zeroes ticks
// R05 - ticks hold at top until external event
// R06 - internal source rolls over every 3072 ticks
// R07 - source select hard reset zero, soft keeps
// R08 - source select only counts when leader
// R09 - leader and root emit cycle start
// R10 - non-leader syncs to received cycle start
// R11 - overlong event clears leader, blocks setting
// R12 - timer enable gates tick counting
// R13 - phy packets accepted when enabled and context on
// R14 - selfid packets accepted only when enabled
// R15 - software sets selfid buffer before enabling
// R16 - node valid cleared on bus reset, set on number
// R17 - software avoids transmit without valid node
// R18 - root flag set if phy reports root
// R19 - cable power flag follows phy report
// R20 - bus index reloads all ones on bus reset
// R21 - node index loaded from phy after selfid
// R22 - never acknowledge destination node 63
// R23 - phy register 0 written without arrival event
package lcn_pkg;
    localparam logic [11:0] LCN_OFS_CTL_SET   = 12'h0000;
    localparam logic [11:0] LCN_OFS_CTL_CLR   = 12'h0004;
    localparam logic [11:0] LCN_OFS_NODE      = 12'h0008;
    localparam logic [11:0] LCN_OFS_TIMER     = 12'h000C;
    localparam logic [11:0] LCN_OFS_EVENT     = 12'h0010;
    localparam int          LCN_BIT_SRC       = 21;
    localparam int          LCN_BIT_LEADER    = 22;
    localparam int          LCN_BIT_TIMER     = 20;
    localparam int          LCN_BIT_PHYPKT    = 10;
    localparam int          LCN_BIT_SELFID    = 9;
    localparam logic [31:0] LCN_CTL_MASK      = 32'h0070_0600;
    localparam int          LCN_BIT_VALID     = 31;
    localparam int          LCN_BIT_ROOT      = 30;
    localparam int          LCN_BIT_CPS       = 27;
    localparam int          LCN_BUS_LSB       = 6;
    localparam logic [9:0]  LCN_BUS_RESET     = 10'h3FF;
    localparam logic [5:0]  LCN_NODE_BCAST    = 6'h3F;
    localparam int          LCN_EVT_OVERLONG  = 0;
    localparam int          LCN_EVT_SELFID    = 1;
    localparam int          LCN_EVT_PHYREG    = 2;
    localparam int          LCN_TICKS_PER_CYC = 3072;
    localparam logic [11:0] LCN_TICK_TOP      = 12'd3071;
    localparam logic [12:0] LCN_TALLY_TOP     = 13'd7999;

    // phy status transfer: register number and its data
    typedef struct packed {
        logic       valid;
        logic [3:0] addr;
        logic [7:0] data;
    } lcn_phy_reg_s;

    // receive side packet classification
    typedef struct packed {
        logic       valid;
        logic       is_phy;
        logic       is_selfid;
        logic [5:0] dest;
    } lcn_rx_pkt_s;
endpackage

//--- hdl/lcn_regs.sv
// link control and node identity registers on apb
`timescale 1ns/1ns
module lcn_regs
    import lcn_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clk_en,
    input  wire logic         soft_reset,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         cyc_tick,
    input  wire logic         ext_cycle_pin,
    input  wire logic         bus_reset_seen,
    input  wire logic         selfid_phase,
    input  wire logic         selfid_finished,
    input  wire lcn_phy_reg_s phy_reg,
    input  wire logic         cps_report,
    input  wire logic         overlong_cycle,
    input  wire logic         ar_req_ctx_on,
    input  wire lcn_rx_pkt_s  rx_pkt,
    input  wire logic         rx_cycle_start,
    input  wire logic [31:0]  rx_cycle_time,
    output logic              cycle_start_tx,
    output logic              phy_pkt_accept,
    output logic              selfid_accept,
    output logic              pkt_ack_ok,
    output logic              phy_reg_arrived_event
);
    // control register: one storage word behind two addresses
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    logic        valid_q;
    logic        root_q;
    logic        cps_q;
    logic [9:0]  bus_q;
    logic [5:0]  node_q;
    logic [11:0] ticks_q;
    logic [12:0] tally_q;
    logic [6:0]  secs_q;
    logic [2:0]  evt_q;
    logic [2:0]  ext_sync_q;
    logic        ext_seen_q;
    logic [31:0] rdata_q;
    logic        ready_q;
    logic        err_q;
    logic        cs_q;
    logic        phyacc_q;
    logic        sidacc_q;
    logic        ack_q;
    logic        preg_q;

    wire acc     = psel && penable && clk_en;
    // a write lands on the completing edge, where the master sees pready high
    wire wr      = acc && pwrite && ready_q;
    wire rd      = acc && !pwrite && !ready_q;
    wire hit_set = (paddr == LCN_OFS_CTL_SET);
    wire hit_clr = (paddr == LCN_OFS_CTL_CLR);
    wire hit_nod = (paddr == LCN_OFS_NODE);
    wire hit_tmr = (paddr == LCN_OFS_TIMER);
    wire hit_evt = (paddr == LCN_OFS_EVENT);
    wire mapped  = hit_set || hit_clr || hit_nod || hit_tmr || hit_evt;

    wire leader  = ctl_q[LCN_BIT_LEADER];
    // source select matters only while this node leads the cycle
    wire ext_src = ctl_q[LCN_BIT_SRC] && leader;                          // [R08]
    wire ext_lvl = ext_sync_q[2];
    // second and third stages must agree before a change counts
    wire ext_now = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2] : ext_seen_q;
    wire ext_evt = ext_now && !ext_seen_q;
    wire run     = ctl_q[LCN_BIT_TIMER] && cyc_tick;                      // [R12]
    wire int_rol = !ext_src && (ticks_q == LCN_TICK_TOP);                  // [R06]
    wire roll    = run && (ext_src ? ext_evt : int_rol);                   // [R04]
    wire set_ovl = overlong_cycle;
    wire ovl_now = evt_q[LCN_EVT_OVERLONG] || set_ovl;
    wire reg0    = phy_reg.valid && (phy_reg.addr == 4'h0);

    function automatic logic [31:0] node_word(input logic v, input logic r, input logic c,
                                              input logic [9:0] b, input logic [5:0] n);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[LCN_BIT_VALID] = v;
        w[LCN_BIT_ROOT]  = r;
        w[LCN_BIT_CPS]   = c;
        w[LCN_BUS_LSB +: 10] = b;
        w[5:0] = n;
        return w;
    endfunction

    always_comb begin
        ctl_d = ctl_q;
        if (wr && hit_set) begin
            ctl_d = ctl_q | (pwdata & LCN_CTL_MASK);                       // [R02]
        end else if (wr && hit_clr) begin
            ctl_d = ctl_q & ~(pwdata & LCN_CTL_MASK);                      // [R03]
        end
        // overlong event forces leader off and keeps it off while pending
        if (ovl_now) begin
            ctl_d[LCN_BIT_LEADER] = 1'b0;                                  // [R11]
        end
        if (soft_reset) begin
            ctl_d = ctl_q & (32'h0000_0001 << LCN_BIT_SRC);                // [R07]
        end
    end

    wire [31:0] rd_mux = (hit_set || hit_clr) ? ctl_q :                    // [R01]
                         hit_nod ? node_word(valid_q, root_q, cps_q, bus_q, node_q) :
                         hit_tmr ? {secs_q, tally_q, ticks_q} :
                         hit_evt ? {29'h0000_0000, evt_q} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q   <= 32'h0000_0000;                                      // [R07]
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            ctl_q   <= ctl_d;
            ready_q <= acc && !ready_q;
            err_q   <= acc && !ready_q && !mapped;
            if (rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;                                               // [R16]
            root_q  <= 1'b0;                                               // [R18]
            cps_q   <= 1'b0;                                               // [R19]
            bus_q   <= LCN_BUS_RESET;                                      // [R20]
            node_q  <= LCN_NODE_BCAST;
        end else if (clk_en) begin
            cps_q <= cps_report;                                           // [R19]
            if (bus_reset_seen) begin
                valid_q <= 1'b0;                                           // [R16]
                root_q  <= 1'b0;
                bus_q   <= LCN_BUS_RESET;                                  // [R20]
            end else begin
                if (wr && hit_nod) begin
                    bus_q <= pwdata[LCN_BUS_LSB +: 10];
                end
                // register 0 lands here whole, in one cycle
                if (reg0 && !selfid_phase) begin
                    node_q  <= phy_reg.data[7:2];                          // [R21] [R23]
                    root_q  <= phy_reg.data[1];                            // [R18]
                    valid_q <= 1'b1;                                       // [R16]
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks_q    <= 12'h000;
            tally_q    <= 13'h0000;
            secs_q     <= 7'h00;
            ext_sync_q <= 3'b000;
            ext_seen_q <= 1'b0;
        end else if (clk_en) begin
            ext_sync_q <= {ext_sync_q[1:0], ext_cycle_pin};
            ext_seen_q <= ext_now;
            if (!leader && rx_cycle_start) begin
                {secs_q, tally_q, ticks_q} <= rx_cycle_time;               // [R10]
            end else if (wr && hit_tmr) begin
                {secs_q, tally_q, ticks_q} <= pwdata;
            end else if (roll) begin
                ticks_q <= 12'h000;                                        // [R04] [R05]
                tally_q <= (tally_q == LCN_TALLY_TOP) ? 13'h0000 : tally_q + 13'd1;
                if (tally_q == LCN_TALLY_TOP) begin
                    secs_q <= secs_q + 7'd1;
                end
            end else if (run && ticks_q != LCN_TICK_TOP) begin
                ticks_q <= ticks_q + 12'd1;                                // [R05] [R12]
            end
        end
    end

    // event bits: hardware set wins over a same-cycle software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_q <= 3'b000;
        end else if (clk_en) begin
            evt_q <= (evt_q & ~((wr && hit_evt) ? pwdata[2:0] : 3'b000))
                   | {phy_reg.valid && !reg0, selfid_finished, set_ovl};   // [R23]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_q     <= 1'b0;
            phyacc_q <= 1'b0;
            sidacc_q <= 1'b0;
            ack_q    <= 1'b0;
            preg_q   <= 1'b0;
        end else if (clk_en) begin
            cs_q     <= roll && leader && root_q;                          // [R09]
            phyacc_q <= rx_pkt.valid && ctl_q[LCN_BIT_PHYPKT] && ar_req_ctx_on
                        && (rx_pkt.is_phy || (rx_pkt.is_selfid && !selfid_phase)); // [R13]
            sidacc_q <= rx_pkt.valid && rx_pkt.is_selfid && selfid_phase
                        && ctl_q[LCN_BIT_SELFID];                          // [R14]
            ack_q    <= rx_pkt.valid && !rx_pkt.is_phy && !rx_pkt.is_selfid
                        && valid_q && (rx_pkt.dest != LCN_NODE_BCAST)       // [R22]
                        && (rx_pkt.dest == node_q);
            preg_q   <= phy_reg.valid && !reg0;                            // [R23]
        end
    end

    assign prdata                = rdata_q;
    assign pready                = ready_q;
    assign pslverr               = err_q;
    assign cycle_start_tx        = cs_q;
    assign phy_pkt_accept        = phyacc_q;
    assign selfid_accept         = sidacc_q;
    assign pkt_ack_ok            = ack_q;
    assign phy_reg_arrived_event = preg_q;
endmodule

//--- verif/lcn_phy_model.sv
// phy side model: bus reset, self-id phase and status transfers
`timescale 1ns/1ns
module lcn_phy_model
    import lcn_pkg::*;
(
    input  wire logic    pclk,
    output logic         bus_reset_seen,
    output logic         selfid_phase,
    output logic         selfid_finished,
    output lcn_phy_reg_s phy_reg,
    output logic         cps_report
);
    initial begin
        bus_reset_seen = 1'b0;
        selfid_phase = 1'b0;
        selfid_finished = 1'b0;
        cps_report = 1'b0;
        phy_reg = '{1'b0, 4'hB, 8'hA5};
    end
    task automatic phase(input logic on);
        @(posedge pclk) selfid_phase <= on;
    endtask
    task automatic bus_reset();
        @(posedge pclk) bus_reset_seen <= 1'b1;
        @(posedge pclk) bus_reset_seen <= 1'b0;
    endtask
    // register 0 goes out only after the phase ends, then one ordinary register
    task automatic report(input logic [5:0] node, input logic root);
        phase(1'b1);
        repeat (3) @(posedge pclk);
        selfid_phase <= 1'b0;
        selfid_finished <= 1'b1;
        cps_report <= 1'b1;
        @(posedge pclk) selfid_finished <= 1'b0;
        phy_reg <= '{1'b1, 4'h0, {node, root, 1'b0}};
        @(posedge pclk) phy_reg <= '{1'b1, 4'h4, 8'h5A};
        // a released transfer bus shows a pattern, not the last data
        @(posedge pclk) phy_reg <= '{1'b0, 4'hB, 8'hA5};
    endtask
endmodule

//--- verif/lcn_regs_monitor.sv
// concurrent checks on the register block ports
`timescale 1ns/1ns
module lcn_regs_monitor
    import lcn_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         clk_en,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic [11:0]  paddr,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire lcn_phy_reg_s phy_reg,
    input wire logic         ar_req_ctx_on,
    input wire lcn_rx_pkt_s  rx_pkt,
    input wire logic         phy_pkt_accept,
    input wire logic         pkt_ack_ok,
    input wire logic         phy_reg_arrived_event
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable && !pready && clk_en;
    endsequence
    chk_ready_next: assert property (s_acc |=> pready)
        else $error("access not answered");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    chk_err_unmapped: assert property (s_acc and paddr > 12'h010 |=> pslverr)
        else $error("unmapped access not refused");
    chk_phy_accept: assert property (phy_pkt_accept |-> $past(rx_pkt.valid && ar_req_ctx_on))
        else $error("phy packet accepted without cause");
    chk_reg0_silent: assert property (phy_reg.valid && phy_reg.addr == 4'h0 |=> !phy_reg_arrived_event)
        else $error("arrival event for register 0");
    chk_reg_arrived: assert property (phy_reg.valid && phy_reg.addr != 4'h0 && clk_en |=> phy_reg_arrived_event)
        else $error("arrival event missing");
    chk_ack_bcast: assert property (pkt_ack_ok |-> $past(rx_pkt.valid && rx_pkt.dest != LCN_NODE_BCAST))
        else $error("acknowledge to node 63");
endmodule

//--- verif/tb_link_control_and_node_identity.sv
// testbench for the link control and node identity registers
`timescale 1ns/1ns
module tb_link_control_and_node_identity
    import lcn_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, soft_reset = 1'b0, cyc_tick = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, overlong_cycle = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rx_cycle_time = '0, q;
    logic ext_cycle_pin = 1'b0, ar_req_ctx_on = 1'b1, rx_cycle_start = 1'b0, e;
    logic bus_reset_seen, selfid_phase, selfid_finished, cps_report, cycle_start_tx;
    logic phy_pkt_accept, selfid_accept, pkt_ack_ok, phy_reg_arrived_event;
    lcn_phy_reg_s phy_reg;
    lcn_rx_pkt_s  rx_pkt = '0;
    int errors = 0, checked = 0, cycles = 0, starts = 0;
    lcn_regs dut_u (.*);
    lcn_phy_model phy_u (.*);
    always #25 pclk = ~pclk;
    // cycle start pulses are counted so a scenario can judge them afterwards
    always @(posedge pclk) begin
        if (cycle_start_tx === 1'b1) begin
            starts <= starts + 1;
        end
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        cmp("read", exp, q);
    endtask
    task automatic send(input lcn_rx_pkt_s p);
        @(posedge pclk) rx_pkt <= p;
        @(posedge pclk) rx_pkt <= '0;
        #1;
    endtask
    // sel: 0 soft reset, 1 overlong cycle, 2 timer tick
    task automatic pulse(input int sel, input int n);
        @(posedge pclk);
        if (sel == 0) begin
            soft_reset <= 1'b1;
        end else if (sel == 1) begin
            overlong_cycle <= 1'b1;
        end else begin
            cyc_tick <= 1'b1;
        end
        repeat (n) @(posedge pclk);
        soft_reset <= 1'b0;
        overlong_cycle <= 1'b0;
        cyc_tick <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic t_ctl();
        rd(LCN_OFS_NODE, 32'h0000_FFFF);
        rd(LCN_OFS_CTL_SET, 32'h0000_0000);
        wr(LCN_OFS_CTL_SET, 32'hFFFF_FFFF);
        rd(LCN_OFS_CTL_CLR, LCN_CTL_MASK);
        wr(LCN_OFS_CTL_CLR, 32'h0040_0200);
        rd(LCN_OFS_CTL_SET, 32'h0030_0400);
        pulse(0, 1);
        rd(LCN_OFS_CTL_SET, 32'h0020_0000);
        bus(1'b0, 12'h020, 32'h0000_0000);
        cmp("unmapped error", 1, e);
        cmp("unmapped data", 0, q);
    endtask
    task automatic t_node();
        phy_u.bus_reset();
        phy_u.report(6'd5, 1'b1);
        rd(LCN_OFS_NODE, 32'hC800_FFC5);
        rd(LCN_OFS_EVENT, 32'h0000_0006);
        wr(LCN_OFS_EVENT, 32'h0000_0007);
        wr(LCN_OFS_NODE, 32'h0000_0AAA);
        rd(LCN_OFS_NODE, 32'hC800_0A85);
        send('{1'b1, 1'b0, 1'b0, 6'd5});
        cmp("ack own", 1, pkt_ack_ok);
        send('{1'b1, 1'b0, 1'b0, 6'd63});
        cmp("ack node 63", 0, pkt_ack_ok);
        phy_u.bus_reset();
        bus(1'b0, LCN_OFS_NODE, 32'h0000_0000);
        cmp("bus reset", 32'h0800_FFC0, q & 32'hBFFF_FFC0);
        send('{1'b1, 1'b0, 1'b0, 6'd5});
        cmp("ack invalid", 0, pkt_ack_ok);
        phy_u.report(6'd7, 1'b0);
        rd(LCN_OFS_NODE, 32'h8800_FFC7);
    endtask
    task automatic t_misc();
        wr(LCN_OFS_CTL_SET, 32'h0000_0600);
        send('{1'b1, 1'b1, 1'b0, 6'd0});
        cmp("phy accept", 1, phy_pkt_accept);
        ar_req_ctx_on <= 1'b0;
        send('{1'b1, 1'b1, 1'b0, 6'd0});
        cmp("phy ctx off", 0, phy_pkt_accept);
        ar_req_ctx_on <= 1'b1;
        phy_u.phase(1'b1);
        send('{1'b1, 1'b0, 1'b1, 6'd0});
        cmp("selfid on", 1, selfid_accept);
        wr(LCN_OFS_CTL_CLR, 32'h0000_0200);
        send('{1'b1, 1'b0, 1'b1, 6'd0});
        cmp("selfid off", 0, selfid_accept);
        phy_u.phase(1'b0);
        wr(LCN_OFS_CTL_SET, 32'h0040_0000);
        pulse(1, 1);
        rd(LCN_OFS_CTL_SET, 32'h0020_0400);
        wr(LCN_OFS_CTL_SET, 32'h0040_0000);
        rd(LCN_OFS_CTL_SET, 32'h0020_0400);
        wr(LCN_OFS_EVENT, 32'h0000_0001);
        wr(LCN_OFS_CTL_SET, 32'h0040_0000);
        rd(LCN_OFS_CTL_SET, 32'h0060_0400);
        wr(LCN_OFS_CTL_CLR, 32'hFFFF_FFFF);
        wr(LCN_OFS_CTL_SET, 32'h0030_0000);
        wr(LCN_OFS_TIMER, 32'h0000_0BFE);
        pulse(2, 2);
        rd(LCN_OFS_TIMER, 32'h0000_1000);
        wr(LCN_OFS_CTL_CLR, 32'h0010_0000);
        pulse(2, 3);
        rd(LCN_OFS_TIMER, 32'h0000_1000);
    endtask
    task automatic t_cycle();
        phy_u.report(6'd5, 1'b1);
        wr(LCN_OFS_CTL_SET, 32'h0070_0000);
        wr(LCN_OFS_TIMER, 32'h0000_0BFE);
        pulse(2, 3);
        rd(LCN_OFS_TIMER, 32'h0000_0BFF);
        cmp("no early start", 0, starts);
        // pin edge needs three stages before it counts as an event
        @(posedge pclk) ext_cycle_pin <= 1'b1;
        pulse(2, 8);
        rd(LCN_OFS_TIMER, 32'h0000_1005);
        cmp("cycle starts", 1, starts);
        wr(LCN_OFS_CTL_CLR, 32'h0040_0000);
        @(posedge pclk);
        rx_cycle_start <= 1'b1;
        rx_cycle_time <= 32'h1234_5678;
        @(posedge pclk) rx_cycle_start <= 1'b0;
        rd(LCN_OFS_TIMER, 32'h1234_5678);
        // a frozen block must ignore a cycle start seen while enable is low
        @(posedge pclk);
        clk_en <= 1'b0;
        rx_cycle_start <= 1'b1;
        rx_cycle_time <= 32'h0000_0000;
        @(posedge pclk);
        rx_cycle_start <= 1'b0;
        clk_en <= 1'b1;
        rd(LCN_OFS_TIMER, 32'h1234_5678);
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_ctl();
        t_node();
        t_misc();
        t_cycle();
        wrap_up();
    end
endmodule
bind lcn_regs lcn_regs_monitor mon_u (.*);
